// ---- src/fcsa_pkg.sv ----
// Purpose: constants for the flash command start-address block
// Assumes: plain register port, 32-bit data
// Notes: offsets and alignment shifts in one place
package fcsa_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] FCSA_OFF_START = 8'h00;
  localparam logic [7:0] FCSA_OFF_END = 8'h04;
  localparam logic [7:0] FCSA_OFF_CTRL = 8'h08;
  localparam logic [7:0] FCSA_OFF_STAT = 8'h0c;
  localparam logic [7:0] FCSA_OFF_INIT = 8'h10;
  localparam logic [31:0] FCSA_START_RST = 32'h0000_0000;
  localparam logic [31:0] FCSA_END_RST = 32'h0000_0000;
  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int FCSA_CTRL_CMD_LSB = 0;
  localparam int FCSA_CTRL_AREA_LSB = 4;
  localparam int FCSA_CTRL_SIZE_LSB = 8;
  localparam int FCSA_CTRL_BLK64 = 12;
  localparam int FCSA_CTRL_SET32 = 13;
  localparam int FCSA_CTRL_DIR = 14;
  localparam int FCSA_INIT_BIT = 0;
  // ----------------------------------------
  // address masks
  // ----------------------------------------
  localparam logic [31:0] FCSA_CODE_KEEP = 32'h0fff_ffff;
  localparam logic [31:0] FCSA_DATA_KEEP = 32'h001f_ffff;
  localparam int FCSA_DF_ARRAY_SHIFT = 17;
  // ----------------------------------------
  // alignment shifts (log2 of boundary)
  // ----------------------------------------
  localparam logic [4:0] FCSA_AL_512 = 5'h09;
  localparam logic [4:0] FCSA_AL_4 = 5'h02;
  localparam logic [4:0] FCSA_AL_8 = 5'h03;
  localparam logic [4:0] FCSA_AL_16K = 5'h0e;
  localparam logic [4:0] FCSA_AL_64K = 5'h10;
  localparam logic [4:0] FCSA_AL_4K = 5'h0c;
  localparam logic [4:0] FCSA_AL_2K = 5'h0b;
  localparam logic [4:0] FCSA_AL_32 = 5'h05;
  localparam logic [2:0] FCSA_SIZE_MAX = 3'h4;

  typedef enum logic [3:0] {
    FCSA_CMD_PROG = 4'h0,
    FCSA_CMD_MPROG = 4'h1,
    FCSA_CMD_DMA = 4'h2,
    FCSA_CMD_BERASE = 4'h3,
    FCSA_CMD_AERASE = 4'h4,
    FCSA_CMD_BLANK = 4'h5,
    FCSA_CMD_CONFIG = 4'h6,
    FCSA_CMD_PROTECT = 4'h7,
    FCSA_CMD_SECURE = 4'h8
  } fcsa_cmd_e;

  typedef enum logic [1:0] {
    FCSA_AREA_USER = 2'h0,
    FCSA_AREA_UBOOT = 2'h1,
    FCSA_AREA_DATA = 2'h2,
    FCSA_AREA_XDATA = 2'h3
  } fcsa_area_e;
endpackage

// ---- src/fcsa_align.sv ----
// Purpose: maps command and area to an alignment shift and masks the address
// Assumes: command codes from the package
// Notes: purely combinational
`timescale 1ns/10ps
module fcsa_align
  import fcsa_pkg::*;
(
  input wire logic [31:0] addr_in,
  input wire logic [3:0] cmd,
  input wire logic [1:0] area,
  input wire logic [2:0] size_sel,
  input wire logic blk64,
  input wire logic set32,
  output logic [31:0] addr_out,
  output logic [4:0] shift
);
  logic [31:0] keep;
  logic [31:0] low_mask;

  always_comb
  begin
    shift = FCSA_AL_4;
    case (cmd)
      FCSA_CMD_PROG:
        shift = (area == FCSA_AREA_USER || area == FCSA_AREA_UBOOT) ? FCSA_AL_512 : FCSA_AL_4;
      FCSA_CMD_MPROG:
        shift = FCSA_AL_8 + ((size_sel > FCSA_SIZE_MAX) ? 5'(FCSA_SIZE_MAX) : 5'(size_sel));
      FCSA_CMD_DMA, FCSA_CMD_BLANK:
        shift = FCSA_AL_4;
      FCSA_CMD_BERASE, FCSA_CMD_AERASE:
      begin
        case (area)
          FCSA_AREA_USER: shift = blk64 ? FCSA_AL_64K : FCSA_AL_16K;
          FCSA_AREA_UBOOT: shift = FCSA_AL_64K;
          FCSA_AREA_DATA: shift = FCSA_AL_4K;
          default: shift = FCSA_AL_2K;
        endcase
      end
      FCSA_CMD_CONFIG, FCSA_CMD_PROTECT, FCSA_CMD_SECURE:
        shift = set32 ? FCSA_AL_32 : FCSA_AL_4;
      default:
        shift = FCSA_AL_4;
    endcase
  end

  always_comb
  begin
    keep = (area == FCSA_AREA_USER || area == FCSA_AREA_UBOOT) ? FCSA_CODE_KEEP : FCSA_DATA_KEEP;
    low_mask = 32'hffff_ffff << shift;
    addr_out = addr_in & keep & low_mask;
  end
endmodule

// ---- src/fcsa_check.sv ----
// Purpose: start/end consistency check on full 32-bit values
// Assumes: end address held outside this module
// Notes: combinational
`timescale 1ns/10ps
module fcsa_check
  import fcsa_pkg::*;
(
  input wire logic [31:0] start_addr,
  input wire logic [31:0] end_addr,
  input wire logic [3:0] cmd,
  input wire logic dir_dec,
  output logic bad
);
  logic order_bad;
  logic cross_bad;
  logic ranged;

  always_comb
  begin
    ranged = (cmd == FCSA_CMD_AERASE) || (cmd == FCSA_CMD_BLANK);
    if (cmd == FCSA_CMD_BLANK && dir_dec)
      order_bad = start_addr < end_addr;
    else
      order_bad = start_addr > end_addr;
    cross_bad = start_addr[31:FCSA_DF_ARRAY_SHIFT] != end_addr[31:FCSA_DF_ARRAY_SHIFT];
    bad = ranged && (order_bad || cross_bad);
  end
endmodule

// ---- src/fcsa_top.sv ----
// Purpose: flash command start-address register with alignment and range check
// Assumes: register port single-cycle, read data one cycle later
// Notes: ready flag and command launch come from the sequencer outside
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps

// Functional notes
// - holds a 32-bit start address for the target area of each command.
// - the address is used by every programming, erase, blank check and setting command.
// - reset and a write of 1 to the init request bit clear the register.
// - writes are dropped from the first command write until ready rises, except ready high in lock.
// - the consistency check uses all 32 bits of start and end.
// - bits 31 to 28 are dropped for code flash commands.
// - bits 31 to 21 are dropped for data flash commands.
// - bits below the command boundary are dropped.
// - programming aligns to 512 bytes in code areas and 4 in data; dma and blank check to 4.
// - multi programming aligns to the chosen write size, 8 to 128 bytes.
// - block erase aligns to 16k or 64k in user area and 64k in user boot.
// - block and area erase align to 4k in data and 2k in extended data.
// - setting commands align to 4 or 32 bytes by setting size.
// - range order error per command and blank check direction locks the sequencer.
// - a range crossing data flash arrays is an error and locks.
module fcsa_top
  import fcsa_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic CMD_FIRST_WRITE,
  input wire logic READY_FLAG,
  input wire logic CMD_LOCK,
  input wire logic CMD_ISSUE,
  output logic [31:0] PROC_ADDR,
  output logic RANGE_ERROR,
  output logic INIT_PULSE
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] start_r;
  logic [31:0] end_r;
  logic [14:0] ctrl_r;
  logic busy_r;
  logic err_r;
  logic ready_d_r;
  logic [31:0] proc_r;
  logic [31:0] masked;
  logic [4:0] shift;
  logic bad;
  logic wr_open;
  logic init_req;
  logic ready_rise;
  logic [3:0] cmd;
  logic [1:0] area;

  assign cmd = ctrl_r[FCSA_CTRL_CMD_LSB +: 4];
  assign area = ctrl_r[FCSA_CTRL_AREA_LSB +: 2];
  assign init_req = WR && ADDR == FCSA_OFF_INIT && WDATA[FCSA_INIT_BIT];
  assign ready_rise = READY_FLAG && !ready_d_r;
  assign wr_open = !busy_r || (READY_FLAG && CMD_LOCK);

  // ----------------------------------------
  // write window tracking
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ready_d_r <= 1'b1;
    else
      ready_d_r <= READY_FLAG;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      busy_r <= 1'b0;
    else if (CMD_FIRST_WRITE)
      busy_r <= 1'b1;
    else if (ready_rise)
      busy_r <= 1'b0;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      start_r <= FCSA_START_RST;
    else if (init_req)
      start_r <= FCSA_START_RST;
    else if (WR && ADDR == FCSA_OFF_START && wr_open)
      start_r <= WDATA;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      end_r <= FCSA_END_RST;
    else if (init_req)
      end_r <= FCSA_END_RST;
    else if (WR && ADDR == FCSA_OFF_END && wr_open)
      end_r <= WDATA;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ctrl_r <= '0;
    else if (WR && ADDR == FCSA_OFF_CTRL && wr_open)
      ctrl_r <= WDATA[14:0];
  end

  // ----------------------------------------
  // command processing address and error
  // ----------------------------------------
  fcsa_align u_align (
    .addr_in(start_r),
    .cmd(cmd),
    .area(area),
    .size_sel(ctrl_r[FCSA_CTRL_SIZE_LSB +: 3]),
    .blk64(ctrl_r[FCSA_CTRL_BLK64]),
    .set32(ctrl_r[FCSA_CTRL_SET32]),
    .addr_out(masked),
    .shift(shift)
  );

  fcsa_check u_check (
    .start_addr(start_r),
    .end_addr(end_r),
    .cmd(cmd),
    .dir_dec(ctrl_r[FCSA_CTRL_DIR]),
    .bad(bad)
  );

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      proc_r <= '0;
    else if (CMD_ISSUE)
      proc_r <= masked;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      err_r <= 1'b0;
    else if (CMD_ISSUE && bad)
      err_r <= 1'b1;
    else if (init_req)
      err_r <= 1'b0;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      INIT_PULSE <= 1'b0;
    else
      INIT_PULSE <= init_req;
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      RDATA <= '0;
    else if (RD)
    begin
      case (ADDR)
        FCSA_OFF_START: RDATA <= start_r;
        FCSA_OFF_END: RDATA <= end_r;
        FCSA_OFF_CTRL: RDATA <= {17'h0, ctrl_r};
        FCSA_OFF_STAT: RDATA <= {24'h0, shift, bad, busy_r, err_r};
        default: RDATA <= '0;
      endcase
    end
    else
      RDATA <= '0;
  end

  assign PROC_ADDR = proc_r;
  assign RANGE_ERROR = err_r;
endmodule

// ---- sim/fcsa_chk.sv ----
// Purpose: port checker for fcsa_top
// Assumes: one clock, async active-low reset
// Notes: bound to the top module at file foot
`timescale 1ns/10ps
module fcsa_chk
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic CMD_ISSUE,
  input wire logic [31:0] PROC_ADDR,
  input wire logic RANGE_ERROR,
  input wire logic INIT_PULSE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  sequence s_init;
    WR && ADDR == 8'h10 && WDATA[0];
  endsequence
  sequence s_rd_start;
    RD && ADDR == 8'h00;
  endsequence
  property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
  property p_init_pulse; s_init |=> INIT_PULSE; endproperty
  property p_pulse_cause; INIT_PULSE |-> $past(WR && ADDR == 8'h10 && WDATA[0]); endproperty
  property p_init_read; s_init ##1 !WR ##1 s_rd_start |=> RDATA == 32'h0; endproperty
  property p_proc_high; CMD_ISSUE |=> PROC_ADDR[31:28] == 4'h0; endproperty
  property p_proc_low; CMD_ISSUE |=> PROC_ADDR[1:0] == 2'h0; endproperty
  property p_err_hold; RANGE_ERROR && !(WR && ADDR == 8'h10 && WDATA[0]) |=> RANGE_ERROR; endproperty
  property p_err_clr; WR && ADDR == 8'h10 && WDATA[0] && !CMD_ISSUE |=> !RANGE_ERROR; endproperty
  property p_err_cause; $rose(RANGE_ERROR) |-> $past(CMD_ISSUE); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  a_init_pulse: assert property (p_init_pulse) else $error("no init pulse");
  a_pulse_cause: assert property (p_pulse_cause) else $error("stray init pulse");
  a_init_read: assert property (p_init_read) else $error("start not cleared");
  a_proc_high: assert property (p_proc_high) else $error("high bits kept");
  a_proc_low: assert property (p_proc_low) else $error("low bits kept");
  a_err_hold: assert property (p_err_hold) else $error("error dropped");
  a_err_clr: assert property (p_err_clr) else $error("error not cleared");
  a_err_cause: assert property (p_err_cause) else $error("error without command");
endmodule

bind fcsa_top fcsa_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CMD_ISSUE(CMD_ISSUE), .PROC_ADDR(PROC_ADDR), .RANGE_ERROR(RANGE_ERROR),
  .INIT_PULSE(INIT_PULSE));

// ---- sim/tb.sv ----
// Purpose: self-checking bench for fcsa_top
// Assumes: read data one cycle after read strobe
// Notes: expected values queued by the driver
`timescale 1ns/10ps
module tb;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, fw = 0, rdy = 1, lck = 0, iss = 0, rd_q = 0, iss_q = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, pa, s, k;
  logic err, ipl;
  logic [31:0] exp_rd[$], exp_pa[$], exp_er[$];
  int failures = 0, checked = 0;
  int unsigned ctl[25] = '{'h90000, 'h90010, 'h20020, 'h20030, 'h30021, 'h40121, 'h50221, 'h60321, 'h70421,
    'h70531, 'h20022, 'he0003, 'h101003, 'h100013, 'hc0023, 'hb0033, 'hc0024, 'hb0034, 'h20025, 'h20006,
    'h52006, 'h20007, 'h52007, 'h20008, 'h52008};
  int unsigned rc[6] = '{'h024, 'h025, 'h4025, 'h4025, 'h024, 'h024};
  int unsigned rs[6] = '{'h2000, 'h1000, 'h1000, 'h2000, 'h1f000, 'h80001000};
  int unsigned re[6] = '{'h1000, 'h2000, 'h2000, 'h1000, 'h21000, 'h2000};
  logic rx[6] = '{1, 0, 1, 0, 1, 1};
  always #25 clk = ~clk;
  fcsa_top DUT (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CMD_FIRST_WRITE(fw), .READY_FLAG(rdy), .CMD_LOCK(lck), .CMD_ISSUE(iss), .PROC_ADDR(pa),
    .RANGE_ERROR(err), .INIT_PULSE(ipl));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [7:0] a, input logic [31:0] x);
    exp_rd.push_back(x);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic go(input logic [31:0] p, input logic r);
    exp_pa.push_back(p);
    exp_er.push_back({31'h0, r});
    @(posedge clk);
    iss <= 1'b1;
    @(posedge clk);
    iss <= 1'b0;
  endtask
  // ----------------------------------------
  // monitor
  // ----------------------------------------
  always @(posedge clk)
  begin
    rd_q <= rd;
    iss_q <= iss;
  end
  always @(negedge clk)
  begin
    if (rd_q)
      cmp(rdata, exp_rd.pop_front());
    if (iss_q)
    begin
      cmp(pa, exp_pa.pop_front());
      cmp({31'h0, err}, exp_er.pop_front());
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(15));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    br(8'h00, 32'h0);
    br(8'h20, 32'h0);
    s = $urandom();
    bw(8'h00, s);
    br(8'h00, s);
    for (int i = 0; i < 25; i++)
    begin
      s = $urandom();
      k = (ctl[i][5:4] < 2) ? 32'h0fff_ffff : 32'h001f_ffff;
      bw(8'h00, s);
      bw(8'h04, s);
      bw(8'h08, {16'h0, ctl[i][15:0]});
      go(s & k & ~((32'h1 << ctl[i][20:16]) - 32'h1), 1'b0);
      br(8'h00, s);
    end
    for (int i = 0; i < 6; i++)
    begin
      bw(8'h10, 32'h1);
      bw(8'h00, rs[i]);
      bw(8'h04, re[i]);
      bw(8'h08, rc[i]);
      k = (rc[i][3:0] == 4'h4) ? 32'h001f_f000 : 32'h001f_fffc;
      go(rs[i] & k, rx[i]);
    end
    bw(8'h10, 32'h1);
    br(8'h00, 32'h0);
    s = $urandom();
    lck <= 1'b1;
    fw <= 1'b1;
    @(posedge clk);
    fw <= 1'b0;
    br(8'h0c, 32'h62);
    bw(8'h00, s);
    br(8'h00, s);
    lck <= 1'b0;
    bw(8'h00, ~s);
    br(8'h00, s);
    rdy <= 1'b0;
    @(posedge clk);
    rdy <= 1'b1;
    bw(8'h00, ~s);
    br(8'h00, ~s);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
